// ### verilog/tru_pkg.sv
// shared constants and types for the temperature read and upload block
package tru_pkg;

	// ****************************************************************
	// widths and fixed codes
	// ****************************************************************
	localparam int BYTE_BITS = 8;
	localparam int WORD_BITS = 16;
	localparam logic [7:0] ADDR_READ = 8'h91;
	localparam logic [7:0] TIMEOUT_LOAD = 8'hFF;
	localparam logic [7:0] TIMEOUT_LAST = 8'h01;
	localparam int ACK_SEL_BIT = 1;
	localparam logic [4:0] BYTE_COUNT = 5'h08;
	localparam logic [4:0] WORD_COUNT = 5'h10;
	localparam logic [4:0] COUNT_LAST = 5'h01;

	// ****************************************************************
	// quarter phases of one scl bit
	// ****************************************************************
	localparam logic [1:0] PH_SETUP = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_HOLD = 2'h2;
	localparam logic [1:0] PH_FALL = 2'h3;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_QUARTER_NS = 2500;
	localparam int T_TIMEOUT_STEP_NS = 1000;
	// least times: round up to whole cycles
	localparam int QUARTER_CYC =
		(T_QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMEOUT_STEP_CYC =
		(T_TIMEOUT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ****************************************************************
	// sequencer states
	// ****************************************************************
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_START = 10'h002,
		S_SEND = 10'h004,
		S_ADDR_ACK = 10'h008,
		S_RECV = 10'h010,
		S_MACK = 10'h020,
		S_STOP = 10'h040,
		S_UP_HI = 10'h080,
		S_UP_LO = 10'h100
	} tru_state_t;

endpackage : tru_pkg

// ### verilog/tru_pin_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none

module tru_pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} tru_sync_t;

	tru_sync_t r_reg;
	tru_sync_t r_next;

	// ff1 feeds only ff2; the filter looks at ff2 and ff3
	always_comb begin
		r_next = r_reg;
		r_next.ff1 = pin;
		r_next.ff2 = r_reg.ff1;
		r_next.ff3 = r_reg.ff2;
		if (r_reg.ff2 == r_reg.ff3) begin
			r_next.level = r_reg.ff3;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= {4{RESET_LEVEL}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign level = r_reg.level;

endmodule : tru_pin_sync

`default_nettype wire

// ### verilog/tru_tick.sv
// free-running divider giving a one-cycle tick every PERIOD cycles
`timescale 1ns/1ps
`default_nettype none

module tru_tick #(
	parameter int PERIOD = 500,
	parameter int CW = 12
) (
	input wire logic clk,
	input wire logic srst,
	output logic tick
);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic tick;
	} tru_tick_t;

	tru_tick_t r_reg;
	tru_tick_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (r_reg.count == LAST) begin
			r_next.count = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.count = r_reg.count + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;

endmodule : tru_tick

`default_nettype wire

// ### verilog/tru_top.sv
// two-wire temperature fetch and three-wire serial upload controller
//
// Behaviour
// - fetch each result as a two-byte read
// - keep first byte high, second byte low
// - ack_select bit 1 picks ack or nack
// - msb first; first byte moved before second
// - address byte 0x91 follows the start
// - ack first data byte, nack the second
// - per bit: scl high, shift in sda, low
// - ack holds sda low; nack pulses then lowers
// - release sda to receive, preload zero after
// - start, address, byte, move, byte, stop
// - frame_sync low announces a pending upload
// - timeout without clock edge during the high byte aborts the upload
// - each rising upload clock presents next bit
// - clock low: count down, await next edge
// - frame_sync high once all bits sent
// - link is frame_sync, upload_data, upload_clock
// - timeout counter starts at 0xFF
// - sixteen bits, high byte first
// - start and stop made while scl high
`timescale 1ns/1ps
`default_nettype none

module tru_top #(
	parameter int QUARTER_CYCLES = tru_pkg::QUARTER_CYC,
	parameter int TIMEOUT_STEP_CYCLES = tru_pkg::TIMEOUT_STEP_CYC
) (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic FETCH_START,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N,
	output logic SCL_O,
	input wire logic UPLOAD_CLOCK_PIN,
	output logic UPLOAD_DATA_PIN,
	output logic FRAME_SYNC_PIN,
	output logic [tru_pkg::BYTE_BITS-1:0] RESULT_HIGH,
	output logic [tru_pkg::BYTE_BITS-1:0] RESULT_LOW,
	output logic ADDR_ACK,
	output logic BUSY,
	output logic FETCH_DONE
);
	import tru_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		tru_state_t st;
		logic [1:0] phase;
		logic [4:0] bits;
		logic [7:0] tx;
		logic [7:0] result_low;
		logic [7:0] result_high;
		logic [1:0] ack_select;
		logic addr_ack;
		logic scl;
		logic sda;
		logic sda_oe_n;
		logic frame_sync;
		logic upload_data;
		logic [7:0] timeout;
		logic [15:0] word;
		logic busy;
		logic done;
	} tru_regs_t;

	tru_regs_t r_reg;
	tru_regs_t r_next;

	logic sda_s;
	logic uclk_s;
	logic qtick;
	logic ttick;

	function automatic logic [4:0] dec_count(input logic [4:0] c);
		dec_count = c - COUNT_LAST;
	endfunction : dec_count

	function automatic logic is_last(input logic [4:0] c);
		is_last = (c == COUNT_LAST);
	endfunction : is_last

	// ****************************************************************
	// pin synchronisers and timebases
	// ****************************************************************
	tru_pin_sync #(
		.RESET_LEVEL(1'b1)
	) u_sda_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.pin(SDA_I),
		.level(sda_s)
	);

	// the upload clock is sampled, not used as a clock
	tru_pin_sync #(
		.RESET_LEVEL(1'b0)
	) u_uclk_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.pin(UPLOAD_CLOCK_PIN),
		.level(uclk_s)
	);

	tru_tick #(
		.PERIOD(QUARTER_CYCLES),
		.CW(12)
	) u_quarter (
		.clk(CLK_SYS),
		.srst(SRST),
		.tick(qtick)
	);

	tru_tick #(
		.PERIOD(TIMEOUT_STEP_CYCLES),
		.CW(12)
	) u_tstep (
		.clk(CLK_SYS),
		.srst(SRST),
		.tick(ttick)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		unique case (r_reg.st)
			S_IDLE: begin
				// both lines idle high
				r_next.busy = 1'b0;
				r_next.scl = 1'b1;
				r_next.sda = 1'b1;
				r_next.sda_oe_n = 1'b0;
				if (FETCH_START) begin
					r_next.busy = 1'b1;
					r_next.st = S_START;
					r_next.phase = PH_SETUP;
				end
			end
			S_START: begin
				if (qtick) begin
					if (r_reg.phase == PH_SETUP) begin
						r_next.sda = 1'b0;
						r_next.phase = PH_RISE;
					end else begin
						r_next.scl = 1'b0;
						r_next.tx = ADDR_READ;
						r_next.bits = BYTE_COUNT;
						r_next.phase = PH_SETUP;
						r_next.st = S_SEND;
					end
				end
			end
			S_SEND: begin
				if (qtick) begin
					r_next.phase = r_reg.phase + 2'h1;
					unique case (r_reg.phase)
						PH_SETUP: begin
							r_next.sda = r_reg.tx[BYTE_BITS-1];
						end
						PH_RISE: begin
							r_next.scl = 1'b1;
						end
						PH_HOLD: begin
						end
						PH_FALL: begin
							r_next.scl = 1'b0;
							r_next.tx = {r_reg.tx[6:0], 1'b0};
							r_next.bits = dec_count(r_reg.bits);
							if (is_last(r_reg.bits)) begin
								r_next.sda_oe_n = 1'b1;
								r_next.st = S_ADDR_ACK;
							end
						end
					endcase
				end
			end
			S_ADDR_ACK: begin
				// acknowledge is recorded, not acted upon
				if (qtick) begin
					r_next.phase = r_reg.phase + 2'h1;
					unique case (r_reg.phase)
						PH_SETUP: begin
						end
						PH_RISE: begin
							r_next.scl = 1'b1;
						end
						PH_HOLD: begin
							r_next.addr_ack = ~sda_s;
						end
						PH_FALL: begin
							r_next.scl = 1'b0;
							r_next.sda = 1'b0;
							r_next.bits = BYTE_COUNT;
							r_next.ack_select[ACK_SEL_BIT] = 1'b0;
							r_next.st = S_RECV;
						end
					endcase
				end
			end
			S_RECV: begin
				if (qtick) begin
					r_next.phase = r_reg.phase + 2'h1;
					unique case (r_reg.phase)
						PH_SETUP: begin
							r_next.sda_oe_n = 1'b1;
						end
						PH_RISE: begin
							r_next.scl = 1'b1;
						end
						PH_HOLD: begin
							// msb arrives first
							r_next.result_low = {r_reg.result_low[6:0], sda_s};
						end
						PH_FALL: begin
							r_next.scl = 1'b0;
							r_next.bits = dec_count(r_reg.bits);
							if (is_last(r_reg.bits)) begin
								r_next.sda = 1'b0;
								r_next.sda_oe_n = 1'b0;
								r_next.st = S_MACK;
							end
						end
					endcase
				end
			end
			S_MACK: begin
				if (qtick) begin
					r_next.phase = r_reg.phase + 2'h1;
					unique case (r_reg.phase)
						PH_SETUP: begin
							r_next.sda = r_reg.ack_select[ACK_SEL_BIT];
						end
						PH_RISE: begin
							r_next.scl = 1'b1;
						end
						PH_HOLD: begin
							// a nack ends its pulse a quarter early
							if (r_reg.ack_select[ACK_SEL_BIT]) begin
								r_next.scl = 1'b0;
							end
						end
						PH_FALL: begin
							r_next.scl = 1'b0;
							r_next.sda = 1'b0;
							if (r_reg.ack_select[ACK_SEL_BIT]) begin
								r_next.st = S_STOP;
							end else begin
								r_next.result_high = r_reg.result_low;
								r_next.ack_select[ACK_SEL_BIT] = 1'b1;
								r_next.bits = BYTE_COUNT;
								r_next.st = S_RECV;
							end
						end
					endcase
				end
			end
			S_STOP: begin
				if (qtick) begin
					if (r_reg.phase == PH_SETUP) begin
						r_next.scl = 1'b1;
						r_next.phase = PH_RISE;
					end else begin
						r_next.sda = 1'b1;
						r_next.phase = PH_SETUP;
						r_next.done = 1'b1;
						r_next.frame_sync = 1'b0;
						r_next.upload_data = 1'b0;
						r_next.timeout = TIMEOUT_LOAD;
						r_next.bits = WORD_COUNT;
						// high byte leads
						r_next.word = {r_reg.result_high, r_reg.result_low};
						r_next.st = S_UP_HI;
					end
				end
			end
			S_UP_HI: begin
				// relies on the computer clocking after sync low
				if (uclk_s) begin
					r_next.upload_data = r_reg.word[WORD_BITS-1];
					r_next.word = {r_reg.word[14:0], 1'b0};
					r_next.st = S_UP_LO;
				end else if (r_reg.bits > BYTE_COUNT && ttick) begin
					// timeout only guards the high byte
					r_next.timeout = r_reg.timeout - 8'h01;
					if (r_reg.timeout == TIMEOUT_LAST) begin
						r_next.frame_sync = 1'b1;
						r_next.st = S_IDLE;
					end
				end
			end
			S_UP_LO: begin
				if (!uclk_s) begin
					r_next.bits = dec_count(r_reg.bits);
					if (is_last(r_reg.bits)) begin
						r_next.frame_sync = 1'b1;
						r_next.st = S_IDLE;
					end else begin
						r_next.st = S_UP_HI;
					end
				end
			end
			default: begin
				r_next.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			r_reg <= '0;
			r_reg.st <= S_IDLE;
			r_reg.scl <= 1'b1;
			r_reg.sda <= 1'b1;
			r_reg.frame_sync <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign SDA_O = r_reg.sda;
	assign SDA_OE_N = r_reg.sda_oe_n;
	assign SCL_O = r_reg.scl;
	assign UPLOAD_DATA_PIN = r_reg.upload_data;
	assign FRAME_SYNC_PIN = r_reg.frame_sync;
	assign RESULT_HIGH = r_reg.result_high;
	assign RESULT_LOW = r_reg.result_low;
	assign ADDR_ACK = r_reg.addr_ack;
	assign BUSY = r_reg.busy;
	assign FETCH_DONE = r_reg.done;

endmodule : tru_top

`default_nettype wire

// ### verif/tru_sva.sv
// assertion checker for the temperature fetch and upload controller
`timescale 1ns/1ps
`default_nettype none

module tru_sva (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic FETCH_START,
	input wire logic SDA_O,
	input wire logic SDA_OE_N,
	input wire logic SCL_O,
	input wire logic UPLOAD_CLOCK_PIN,
	input wire logic UPLOAD_DATA_PIN,
	input wire logic FRAME_SYNC_PIN,
	input wire logic BUSY,
	input wire logic FETCH_DONE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	// ****
	// bus edges while scl is high
	// ****
	sequence s_start;
		SCL_O && SDA_O && !SDA_OE_N ##1 SCL_O && !SDA_O;
	endsequence
	sequence s_stop;
		SCL_O && !SDA_O && !SDA_OE_N ##1 SCL_O && SDA_O && !SDA_OE_N;
	endsequence
	a_reset_idle: assert property ($fell(SRST) |-> SCL_O && FRAME_SYNC_PIN && !BUSY)
		else $error("lines not idle after reset");
	a_start_cond: assert property (s_start |-> BUSY)
		else $error("start condition outside a fetch");
	a_stop_cond: assert property (s_stop |-> FETCH_DONE && !FRAME_SYNC_PIN)
		else $error("stop without done and frame sync");
	a_done_pulse: assert property (FETCH_DONE |=> !FETCH_DONE)
		else $error("done longer than one cycle");
	a_fetch_busy: assert property (FETCH_START && !BUSY |=> BUSY [*8])
		else $error("fetch request not taken");
	a_oe_release: assert property ($rose(SDA_OE_N) |-> !SCL_O)
		else $error("sda released while scl high");
	a_oe_return: assert property ($fell(SDA_OE_N) |-> !SDA_O && !SCL_O)
		else $error("sda not preloaded low");
	a_sync_busy: assert property (!FRAME_SYNC_PIN |-> BUSY)
		else $error("frame sync low while idle");
	a_frame_end: assert property ($rose(FRAME_SYNC_PIN) |=> !BUSY)
		else $error("busy after frame end");
	// data is also cleared as the frame opens, without any clock
	a_data_edge: assert property (
		$changed(UPLOAD_DATA_PIN) && !$fell(FRAME_SYNC_PIN) |->
		!FRAME_SYNC_PIN && $past(UPLOAD_CLOCK_PIN, 3))
		else $error("upload data moved without clock");
endmodule : tru_sva

`default_nettype wire

// ### verif/tru_far.sv
// far-side model: sensor on the two-wire bus and the logging computer
`timescale 1ns/1ps
`default_nettype none

module tru_far (
	input wire logic scl,
	input wire logic sda_m,
	input wire logic oe_n,
	output logic sda,
	input wire logic [15:0] word,
	input wire logic pc_on,
	input wire logic fsync,
	input wire logic udata,
	output logic uclk,
	output logic [7:0] addr,
	output logic [1:0] acks,
	output logic [15:0] got
);
	int n = 0;
	logic drv = 1'b1;
	// pull-up: a released line reads high
	assign sda = (oe_n | sda_m) & drv;
	// scl may fall in the same step as sda; let it settle first
	always @(negedge sda) #1 if (scl) n = 0;
	always @(posedge scl) begin
		n = n + 1;
		if (n <= 8) addr = {addr[6:0], sda};
		if (n == 18) acks[0] = sda;
		if (n == 27) acks[1] = sda;
	end
	// sensor changes sda only while scl is low, msb first
	always @(negedge scl) begin
		if (n == 8) drv = 1'b0;
		else if (n >= 9 && n <= 16) drv = word[24-n];
		else if (n >= 18 && n <= 25) drv = word[25-n];
		else drv = 1'b1;
	end
	// computer clocks only once the frame is announced
	initial uclk = 1'b0;
	always begin
		wait (pc_on && !fsync);
		#7;
		for (int i = 0; i < 16; i++) begin
			uclk = 1'b1;
			#60;
			got = {got[14:0], udata};
			uclk = 1'b0;
			#64;
		end
		wait (fsync);
	end
endmodule : tru_far

`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the fetch and upload controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic fetch_start = 1'b0;
	logic pc_on = 1'b0;
	logic [15:0] word = 16'h0000;
	logic sda, sda_o, oe_n, scl, uclk, udata, fsync, ack, busy, done;
	logic [7:0] r_hi, r_lo, addr;
	logic [1:0] acks;
	logic [15:0] got;
	int errors = 0;
	int checks = 0;
	initial forever #2.5 clk_sys = ~clk_sys;
	tru_top #(.QUARTER_CYCLES(4), .TIMEOUT_STEP_CYCLES(4)) DUT (
		.CLK_SYS(clk_sys), .SRST(srst), .FETCH_START(fetch_start),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(oe_n), .SCL_O(scl),
		.UPLOAD_CLOCK_PIN(uclk), .UPLOAD_DATA_PIN(udata),
		.FRAME_SYNC_PIN(fsync), .RESULT_HIGH(r_hi), .RESULT_LOW(r_lo),
		.ADDR_ACK(ack), .BUSY(busy), .FETCH_DONE(done));
	tru_far u_far (.scl(scl), .sda_m(sda_o), .oe_n(oe_n), .sda(sda),
		.word(word), .pc_on(pc_on), .fsync(fsync), .udata(udata),
		.uclk(uclk), .addr(addr), .acks(acks), .got(got));
	// ****
	// shared tasks
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	// second request mid-fetch must be ignored
	task automatic fetch(output int n);
		@(negedge clk_sys) fetch_start = 1'b1;
		@(negedge clk_sys) fetch_start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(negedge clk_sys);
			fetch_start = (n == 50);
			n++;
		end
		fetch_start = 1'b0;
		check(done, 16'h0001);
	endtask : fetch
	task automatic wait_idle;
		int n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		check(busy, 16'h0000);
	endtask : wait_idle
	// ****
	// scenarios
	// ****
	task automatic test_reset;
		@(negedge clk_sys);
		check({scl, sda_o, oe_n, fsync, udata, busy, done}, 16'h0068);
		check({r_hi, r_lo}, 16'h0000);
		check(ack, 16'h0000);
		$display("reset test done");
	endtask : test_reset
	task automatic test_upload(input logic [15:0] w);
		int n;
		word = w;
		pc_on = 1'b1;
		fetch(n);
		check({r_hi, r_lo}, w);
		check({ack, addr}, 16'h0191);
		check(acks, 16'h0002);
		wait_idle();
		check(got, w);
		check({fsync, busy}, 16'h0002);
		repeat (20) @(negedge clk_sys);
		check(busy, 16'h0000);
		$display("upload test %h done", w);
	endtask : test_upload
	task automatic test_timeout;
		int n;
		pc_on = 1'b0;
		fetch(n);
		n = 0;
		while (fsync !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		check(n >= 1012 && n <= 1028, 16'h0001);
		wait_idle();
		check({uclk, busy}, 16'h0000);
		$display("timeout test done");
	endtask : test_timeout
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		srst = 1'b0;
		test_reset();
		test_upload(16'hA53C);
		test_upload(16'h8001);
		test_timeout();
		give_verdict();
	end
endmodule : testbench

bind tru_top tru_sva u_sva (.CLK_SYS(CLK_SYS), .SRST(SRST),
	.FETCH_START(FETCH_START), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
	.SCL_O(SCL_O), .UPLOAD_CLOCK_PIN(UPLOAD_CLOCK_PIN),
	.UPLOAD_DATA_PIN(UPLOAD_DATA_PIN), .FRAME_SYNC_PIN(FRAME_SYNC_PIN),
	.BUSY(BUSY), .FETCH_DONE(FETCH_DONE));

`default_nettype wire
